// File: src/sbd_defs.svh
// constants for the serial board decode and interrupt look-ahead block
`ifndef SBD_DEFS_SVH
`define SBD_DEFS_SVH

// ==========================================================================
// register offsets (byte addresses on apb)
`define SBD_OFF_CFG       8'h00
`define SBD_OFF_STAT      8'h04

// ==========================================================================
// configuration register field positions
`define SBD_CFG_BASE_LSB  0
`define SBD_CFG_LEVEL_LSB 4
`define SBD_CFG_CLK_SEL_CTRL1_CHAN_B_BIT  8
`define SBD_CFG_CLK_SEL_CTRL3_CHAN_A_BIT  9
`define SBD_CFG_MODE_LSB  10
`define SBD_CFG_W         12

// ==========================================================================
// status register field positions
`define SBD_STAT_VI_LSB   0
`define SBD_STAT_PEND_LSB 8
`define SBD_STAT_BLK_BIT  11
`define SBD_STAT_INT_BIT  12
`define SBD_STAT_HIT_BIT  13
`define SBD_STAT_W        14

// ==========================================================================
// reset values and limits
`define SBD_RST_BASE      4'h2
`define SBD_RST_LEVEL     4'h2
`define SBD_RST_MODE      2'h2
`define SBD_LEVEL_MIN     4'h1
`define SBD_LEVEL_MAX     4'h8
`define SBD_NUM_VI        8
`define SBD_NUM_PORTS     16
`define SBD_NUM_CTRL      3
`define SBD_NUM_CHAN      6

`endif

// File: src/sbd_pkg.sv
// types shared by the serial board decode and interrupt look-ahead block
package sbd_pkg;

  // ========================================================================
  // configuration word, high field first in bit order
  typedef struct packed {
    logic [1:0] int_mode;             // host interrupt response mode 0..2
    logic       clk_sel_ctrl3_chan_a; // controller 3 channel a from timer 1
    logic       clk_sel_ctrl1_chan_b; // controller 1 channel b from timer 1
    logic [3:0] level;                // priority level 1..8
    logic [3:0] base;                 // upper hex digit of port block
  } sbd_cfg_s;

  // ========================================================================
  // status word
  typedef struct packed {
    logic       hit;                  // last bus cycle hit the block
    logic       int_active;           // bus interrupt line pulled
    logic       blocked;              // higher priority line low
    logic [2:0] pending;              // controller requests pending
    logic [7:0] vi_n;                 // synchronised priority lines
  } sbd_stat_s;

endpackage : sbd_pkg

// File: src/sbd_sync.sv
// two flip-flop synchroniser for pins arriving from outside pclk
module sbd_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // ==========================================================================
  // first stage is read only by the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : sbd_sync

// File: src/sbd_top.sv
// port block decode, look-ahead interrupt priority and baud clock routing
`include "sbd_defs.svh"

module sbd_top #(
  parameter int ADDR_W = 8
) (
  // apb clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // host bus port cycle
  input  wire logic [7:0]        bus_addr,
  input  wire logic              bus_io_req,
  // priority lines, open drain, active low
  input  wire logic [7:0]        vi_n_in,
  output logic      [7:0]        vi_n_out,
  output logic      [7:0]        vi_n_oe,
  // bus interrupt request, open drain, active low
  output logic                   int_n_out,
  output logic                   int_n_oe,
  // on-board controllers and timer
  input  wire logic [2:0]        dev_irq_n,
  input  wire logic [2:0]        timer_zc,
  output logic      [15:0]       dev_sel,
  output logic                   board_hit,
  output logic      [5:0]        baud_clk,
  output logic      [1:0]        irq_mode
);

  // ==========================================================================
  // declarations
  sbd_pkg::sbd_cfg_s  cfg_reg;
  sbd_pkg::sbd_cfg_s  cfg_wr;
  sbd_pkg::sbd_stat_s stat_w;
  logic [7:0]         addr_s;
  logic               io_req_s;
  logic [7:0]         vi_n_s;
  logic [2:0]         irq_n_s;
  logic [15:0]        dev_sel_next;
  logic               hit_next;
  logic [7:0]         sense_mask;
  logic [8:0]         sense_ext;
  logic [8:0]         drive_ext;
  logic [7:0]         drive_mask;
  logic [2:0]         pending;
  logic               any_pending;
  logic               blocked;
  logic               int_next;
  logic [7:0]         vi_oe_next;
  logic [5:0]         baud_next;
  logic               apb_setup;
  logic               apb_wr_done;
  logic [7:0]         byte_addr;
  logic               sel_cfg;
  logic               sel_stat;
  logic               unmapped;
  logic [31:0]        rdata_next;
  logic               level_ok;
  logic               hit_reg;

  // ==========================================================================
  // pin synchronisers, one instance per pin group except timer_zc, which is used unsynchronised
  sbd_sync #(
    .W       (8),
    .RST_VAL (8'h00)
  ) u_sync_addr (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (bus_addr),
    .q       (addr_s)
  );

  sbd_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_sync_io (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (bus_io_req),
    .q       (io_req_s)
  );

  sbd_sync #(
    .W       (8),
    .RST_VAL (8'hff)
  ) u_sync_vi (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (vi_n_in),
    .q       (vi_n_s)
  );

  sbd_sync #(
    .W       (3),
    .RST_VAL (3'h7)
  ) u_sync_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (dev_irq_n),
    .q       (irq_n_s)
  );

  // ==========================================================================
  // port block address decode
  // block hit on base digit
  assign hit_next     = io_req_s && (addr_s[7:4] == cfg_reg.base);
  assign dev_sel_next = hit_next ? (16'h0001 << addr_s[3:0]) : 16'h0000;

  // ==========================================================================
  // look-ahead priority masks from the level setting
  // sense every line below the level
  assign sense_ext  = (9'h001 << cfg_reg.level) - 9'h001;
  assign sense_mask = sense_ext[7:0];
  // level eight shifts past the top line and drives none
  assign drive_ext  = 9'h001 << cfg_reg.level;
  assign drive_mask = drive_ext[7:0];

  // ==========================================================================
  // interrupt request and blocking
  assign pending     = ~irq_n_s;
  assign any_pending = |pending;
  // all sensed lines are looked at together
  // level is never 0, so line 0 is always in the mask
  assign blocked     = |(~vi_n_s & sense_mask);
  // own request held back while blocked
  assign int_next    = any_pending && !blocked;
  // own line pulled while requests pend
  assign vi_oe_next  = any_pending ? drive_mask : 8'h00;

  // ==========================================================================
  // baud clock routing, order 1a 1b 2a 2b 3a 3b
  // default one timer channel per controller
  assign baud_next[0] = timer_zc[0];
  assign baud_next[1] = cfg_reg.clk_sel_ctrl1_chan_b ? timer_zc[1] : timer_zc[0];
  assign baud_next[2] = timer_zc[1];
  assign baud_next[3] = timer_zc[1];
  assign baud_next[4] = cfg_reg.clk_sel_ctrl3_chan_a ? timer_zc[1] : timer_zc[2];
  assign baud_next[5] = timer_zc[2];

  // ==========================================================================
  // apb decode
  assign byte_addr   = {paddr[7:2], 2'b00};
  assign sel_cfg     = (byte_addr == `SBD_OFF_CFG);
  assign sel_stat    = (byte_addr == `SBD_OFF_STAT);
  assign unmapped    = !(sel_cfg || sel_stat) || (paddr[ADDR_W-1:0] > 8'hff);
  assign apb_setup   = psel && !penable && !pready;
  assign apb_wr_done = psel && penable && pready && pwrite && sel_cfg;

  // ==========================================================================
  // candidate configuration from write data
  assign cfg_wr.base                 = pwdata[`SBD_CFG_BASE_LSB +: 4];
  assign cfg_wr.level                = pwdata[`SBD_CFG_LEVEL_LSB +: 4];
  assign cfg_wr.clk_sel_ctrl1_chan_b = pwdata[`SBD_CFG_CLK_SEL_CTRL1_CHAN_B_BIT];
  assign cfg_wr.clk_sel_ctrl3_chan_a = pwdata[`SBD_CFG_CLK_SEL_CTRL3_CHAN_A_BIT];
  assign cfg_wr.int_mode             = pwdata[`SBD_CFG_MODE_LSB +: 2];
  assign level_ok = (cfg_wr.level >= `SBD_LEVEL_MIN) && (cfg_wr.level <= `SBD_LEVEL_MAX);

  // ==========================================================================
  // status word and read mux
  assign stat_w.hit        = hit_reg;
  assign stat_w.int_active = int_n_oe;
  assign stat_w.blocked    = blocked;
  assign stat_w.pending    = pending;
  assign stat_w.vi_n       = vi_n_s;
  assign rdata_next = sel_cfg  ? {20'h00000, cfg_reg} :
                      sel_stat ? {18'h00000, stat_w} : 32'h00000000;

  // ==========================================================================
  // apb answer, one wait-free access phase after each setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup && unmapped;
      prdata  <= (apb_setup && !pwrite) ? rdata_next : 32'h00000000;
    end
  end

  // ==========================================================================
  // configuration register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg.base                 <= `SBD_RST_BASE;
      cfg_reg.level                <= `SBD_RST_LEVEL;
      cfg_reg.clk_sel_ctrl1_chan_b <= 1'b0;
      cfg_reg.clk_sel_ctrl3_chan_a <= 1'b0;
      cfg_reg.int_mode             <= `SBD_RST_MODE;
    end
    else if (apb_wr_done)
    begin
      cfg_reg.base                 <= cfg_wr.base;
      cfg_reg.level                <= level_ok ? cfg_wr.level : cfg_reg.level;
      cfg_reg.clk_sel_ctrl1_chan_b <= cfg_wr.clk_sel_ctrl1_chan_b;
      cfg_reg.clk_sel_ctrl3_chan_a <= cfg_wr.clk_sel_ctrl3_chan_a;
      // modes 0..2 kept, code 3 ignored
      cfg_reg.int_mode             <= (cfg_wr.int_mode == 2'h3) ? cfg_reg.int_mode : cfg_wr.int_mode;
    end
  end

  // ==========================================================================
  // decode outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dev_sel   <= 16'h0000;
      board_hit <= 1'b0;
      hit_reg   <= 1'b0;
    end
    else
    begin
      dev_sel   <= dev_sel_next;
      board_hit <= hit_next;
      hit_reg   <= io_req_s ? hit_next : hit_reg; // held until next bus port cycle
    end
  end

  // ==========================================================================
  // bus interrupt and priority line drivers, low level when enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vi_n_out  <= 8'h00;
      vi_n_oe   <= 8'h00;
      int_n_out <= 1'b0;
      int_n_oe  <= 1'b0;
    end
    else
    begin
      vi_n_out  <= 8'h00;
      vi_n_oe   <= vi_oe_next;
      int_n_out <= 1'b0;
      int_n_oe  <= int_next;
    end
  end

  // ==========================================================================
  // baud clocks and mode to the controllers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_clk <= 6'h00;
      irq_mode <= `SBD_RST_MODE;
    end
    else
    begin
      baud_clk <= baud_next;
      irq_mode <= cfg_reg.int_mode;
    end
  end

endmodule : sbd_top

// File: testbench/sbd_bus_model.sv
// far side of the priority chain: other boards, processor and pull-ups
module sbd_bus_model (
  // pulls from other participants, bit k for level k
  input  wire logic [7:0] ext_pull,
  // board's own open-drain drives
  input  wire logic [7:0] vi_n_oe,
  input  wire logic [7:0] vi_n_out,
  input  wire logic       int_n_oe,
  input  wire logic       int_n_out,
  // resolved bus lines
  output logic      [7:0] vi_n,
  output logic            int_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // level zero pulls line 0 only, level eight pulls none
  // released lines return high through the bus pull-ups
  assign vi_n  = ~(ext_pull | (vi_n_oe & ~vi_n_out));
  assign int_n = ~(int_n_oe & ~int_n_out);
endmodule : sbd_bus_model

// File: testbench/sbd_top_sva.sv
// concurrent checks on the ports of the board decode block
module sbd_top_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // priority and interrupt lines
  input wire logic [7:0]  vi_n_in,
  input wire logic [7:0]  vi_n_out,
  input wire logic [7:0]  vi_n_oe,
  input wire logic        int_n_out,
  input wire logic        int_n_oe,
  // board side
  input wire logic [2:0]  dev_irq_n,
  input wire logic [2:0]  timer_zc,
  input wire logic [15:0] dev_sel,
  input wire logic        board_hit,
  input wire logic [5:0]  baud_clk,
  input wire logic [1:0]  irq_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a sensed line above the driven one is low
  logic blk_now;
  assign blk_now = (vi_n_oe != 8'h00) && ((~vi_n_in & (vi_n_oe - 8'h01)) != 8'h00);
  // ========================================================================
  // assertions
  chk_apb_answer: assert property (psel && !penable && !pready |=> pready)
    else $error("no answer after setup");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_qual: assert property (pslverr || prdata != 32'h0 |-> pready)
    else $error("response outside access");
  chk_pins_low: assert property (vi_n_out == 8'h00 && !int_n_out)
    else $error("open drain drives high");
  chk_one_line: assert property ($onehot0(vi_n_oe) && !vi_n_oe[0])
    else $error("bad driven line set");
  chk_release_line: assert property ((dev_irq_n == 3'h7) [*3] |=> vi_n_oe == 8'h00 && !int_n_oe)
    else $error("line held without request");
  chk_block_int: assert property ((blk_now && $stable(vi_n_oe)) [*4] |-> !int_n_oe)
    else $error("interrupt not blocked");
  chk_sel_hit: assert property (board_hit == (dev_sel != 16'h0) && $onehot0(dev_sel))
    else $error("select not one-hot with hit");
  chk_baud_fixed: assert property ($past(presetn) |-> baud_clk[0] == $past(timer_zc[0])
    && baud_clk[3:2] == {2{$past(timer_zc[1])}} && baud_clk[5] == $past(timer_zc[2]))
    else $error("fixed baud route wrong");
  chk_mode_legal: assert property (irq_mode != 2'h3)
    else $error("illegal mode exported");
  // main scenarios
  cover property (int_n_oe);
  cover property (blk_now);
  cover property (board_hit);
  cover property (pslverr);
endmodule : sbd_top_chk

bind sbd_top sbd_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .vi_n_in(vi_n_in), .vi_n_out(vi_n_out),
  .vi_n_oe(vi_n_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe), .dev_irq_n(dev_irq_n),
  .timer_zc(timer_zc), .dev_sel(dev_sel), .board_hit(board_hit), .baud_clk(baud_clk), .irq_mode(irq_mode));

// File: testbench/sbd_top_test.sv
// self-checking bench for port decode, priority look-ahead and baud routing
module sbd_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================================
  // stimulus, outputs and bookkeeping
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        bus_io_req = 1'b0, pready, pslverr, int_n_out, int_n_oe, int_n, board_hit, er;
  logic [7:0]  paddr = 8'h00, bus_addr = 8'h00, ext_pull = 8'h00, vi_n, vi_n_out, vi_n_oe;
  logic [2:0]  dev_irq_n = 3'h7, timer_zc = 3'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] dev_sel;
  logic [5:0]  baud_clk, exp;
  logic [1:0]  irq_mode;
  int          error_cnt = 0, num_checks = 0, cyc = 0;
  sbd_pkg::sbd_cfg_s cfg;
  // 100 MHz clock
  always #5 pclk = ~pclk;
  // ========================================================================
  // design and far side
  sbd_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_addr(bus_addr), .bus_io_req(bus_io_req), .vi_n_in(vi_n), .vi_n_out(vi_n_out),
    .vi_n_oe(vi_n_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe), .dev_irq_n(dev_irq_n),
    .timer_zc(timer_zc), .dev_sel(dev_sel), .board_hit(board_hit), .baud_clk(baud_clk),
    .irq_mode(irq_mode));
  sbd_bus_model u_bus (.ext_pull(ext_pull), .vi_n_oe(vi_n_oe), .vi_n_out(vi_n_out),
    .int_n_oe(int_n_oe), .int_n_out(int_n_out), .vi_n(vi_n), .int_n(int_n));
  // ========================================================================
  // tasks
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wcfg(input logic [3:0] b, input logic [3:0] l, input logic [1:0] o, input logic [1:0] m);
    cfg = {m, o, l, b};
    apb(1'b1, 8'h00, {20'h0, cfg});
    repeat (2) @(posedge pclk);
  endtask : wcfg
  // board pins, then the three-edge sync and register latency
  task automatic pins(input logic [7:0] a, input logic r, input logic [2:0] irq, input logic [7:0] ext);
    @(posedge pclk);
    bus_addr   <= a;
    bus_io_req <= r;
    dev_irq_n  <= irq;
    ext_pull   <= ext;
    repeat (4) @(posedge pclk);
  endtask : pins
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end
  // ========================================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0822);
    apb(1'b0, 8'h08, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    pins(8'h25, 1'b1, 3'h7, 8'h00);
    chk({board_hit, dev_sel}, {1'b1, 16'h0020});
    // status after a hit, then writes to status and unmapped space ignored
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_20ff);
    apb(1'b1, 8'h04, 32'hffff_ffff);
    apb(1'b1, 8'h08, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0822);
    // every base digit, each with a different offset, plus the next block
    for (int j = 0; j < 16; j++)
    begin
      wcfg(j[3:0], 4'h2, 2'h0, 2'h2);
      pins({j[3:0], j[3:0]}, 1'b1, 3'h7, 8'h00);
      chk({board_hit, dev_sel}, {1'b1, 16'h0001 << j});
      pins({j[3:0] + 4'h1, j[3:0]}, 1'b1, 3'h7, 8'h00);
      chk({board_hit, dev_sel}, 32'h0);
    end
    pins(8'h00, 1'b0, 3'h7, 8'h00);
    // each level: lower lines ignored, a higher line blocks, release
    for (int n = 1; n <= 8; n++)
    begin
      wcfg(4'h2, n[3:0], 2'h0, 2'h2);
      pins(8'h00, 1'b0, ~(3'h1 << (n % 3)), 8'hff << n);
      chk({~int_n, vi_n_oe}, {1'b1, 8'h01 << n});
      pins(8'h00, 1'b0, ~(3'h1 << (n % 3)), 8'h01 << (n - 1));
      chk({~int_n, vi_n_oe}, {1'b0, 8'h01 << n});
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, {18'h0, 3'h1, 3'h1 << (n % 3), ~((8'h01 << (n - 1)) | (8'h01 << n))});
      pins(8'h00, 1'b0, 3'h7, 8'h01 << (n - 1));
      chk({~int_n, vi_n_oe}, 32'h0);
    end
    // out-of-range levels keep level 8
    for (int k = 0; k < 2; k++)
    begin
      wcfg(4'h2, (k == 0) ? 4'h0 : 4'h9, 2'h0, 2'h2);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000_0882);
    end
    // reset in mid-run restores the defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0822);
    for (int m = 0; m < 4; m++)
    begin
      wcfg(4'h2, 4'h2, 2'h0, m[1:0]);
      chk({30'h0, irq_mode}, (m == 3) ? 32'h2 : m);
    end
    // baud sources for each option pair and timer channel
    for (int o = 0; o < 4; o++)
    begin
      wcfg(4'h2, 4'h2, o[1:0], 2'h2);
      for (int z = 0; z < 3; z++)
      begin
        @(posedge pclk);
        timer_zc <= 3'h1 << z;
        repeat (2) @(posedge pclk);
        exp = {timer_zc[2], o[1] ? timer_zc[1] : timer_zc[2], {2{timer_zc[1]}},
               o[0] ? timer_zc[1] : timer_zc[0], timer_zc[0]};
        chk({26'h0, baud_clk}, {26'h0, exp});
      end
    end
    close_out();
  end
endmodule : sbd_top_test
